/* File: sfsi_pkg.sv */
// package of constants and types for the framed serial slave interface
// Summary of operation
// - discard frames without exactly 16 clocks
// - chip select high: output tristated, input ignored
// - sample on rising edge, shift on falling
// - both streams most significant bit first
// - master sends address, data, parity fields
// - device returns error, address, indicator, data, parity
// - answer to each frame returned next frame
// - failed previous transfer sets error bit
// - write-only answers zero, except two status commands
// - bank 0x10 by sub-address, indicator set
// - both frames use odd parity
package sfsi_pkg;
    localparam int         FRAME_BITS      = 16;
    localparam logic [4:0] FRAME_BITS_M1   = 5'h0F;
    localparam logic [4:0] FRAME_BITS_C    = 5'h10;
    localparam int         POS_ERR         = 15;
    localparam int         POS_ADDR_HI     = 14;
    localparam int         POS_ADDR_LO     = 10;
    localparam int         POS_RW          = 9;
    localparam int         POS_DATA_HI     = 8;
    localparam int         POS_DATA_LO     = 1;
    localparam int         POS_PAR         = 0;
    localparam logic [4:0] ADDR_RO_BANK    = 5'h10;
    localparam logic [4:0] ADDR_LOCK_CMD   = 5'h0C;
    localparam logic [4:0] ADDR_STAGE_CMD  = 5'h0D;
    localparam int         LOCK_BIT        = 1;
    localparam int         OUTDIS_BIT      = 1;
    localparam int         STOP_BIT        = 3;
    localparam int         START_BIT       = 2;
    localparam int         SWRST_BIT       = 2;
    localparam logic [7:0] REG_RESET       = 8'h00;
    localparam logic [15:0] FRAME_RESET    = 16'h0000;
    localparam logic [3:0] ADDR_MIN_WR     = 4'h1;
    localparam logic [4:0] ADDR_MAX_WR     = 5'h12;
    // half period covers both synchronisers and the device's shift, so no bit is read stale
    localparam int         SCK_HALF_DIV    = 8;
    localparam logic [2:0] SCK_HALF_M1     = 3'h7;
    localparam logic [1:0] ST_DONE         = 2'h1;
    localparam logic [1:0] ST_PERR         = 2'h2;
    localparam logic [1:0] ST_LERR         = 2'h0;
    localparam logic [7:0] REG_STATUS      = 8'h00;
    localparam logic [7:0] REG_MASK        = 8'h01;
    localparam logic [7:0] REG_TX          = 8'h02;
    localparam logic [7:0] REG_RX          = 8'h03;
    localparam logic [7:0] REG_CTRL        = 8'h04;
    typedef logic [15:0] sfsi_frame_t;
    typedef enum logic [1:0] {SFSI_IDLE, SFSI_LEAD, SFSI_XFER, SFSI_LAG} sfsi_mst_state_t;
    function automatic logic sfsi_odd_par(input logic [14:0] v);
        return ~(^v);
    endfunction : sfsi_odd_par
endpackage : sfsi_pkg

/* File: sfsi_link_if.sv */
// link carrier between the serial slave and the master
`timescale 1ns/1ps
interface sfsi_link_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    modport device (input cs_n, input sck, input mosi, output miso, output miso_oe);
    modport master (output cs_n, output sck, output mosi, input miso, input miso_oe);
endinterface : sfsi_link_if

/* File: sfsi_sync.sv */
// two-flop synchroniser for link pins
`timescale 1ns/1ps
module sfsi_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys_in,
    input  wire logic         resetn_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] d_in,
    input  wire logic [W-1:0] rst_val_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else if (ce_in) begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
    logic unused_rst;
    assign unused_rst = ^rst_val_in;
endmodule : sfsi_sync

/* File: sfsi_device.sv */
// device end: framed serial slave with a small register bank
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
module sfsi_device
    import sfsi_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic        ce_in,
    sfsi_link_if.device      link,
    input  wire logic [7:0]  ro_data_in [32],
    output logic [7:0]       wr_regs_out [32],
    output logic             lock_out,
    output logic             out_dis_out,
    output logic             sw_reset_out,
    output logic             frame_err_out
);
    logic [2:0] s_q;
    // cs_n resets high in the synchroniser view via inversion
    sfsi_sync #(.W(3)) u_sync (
        .clk_sys_in (clk_sys_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .d_in       ({~link.cs_n, link.sck, link.mosi}),
        .rst_val_in (3'h0),
        .q_out      (s_q)
    );
    logic cs_act, sck_s, mosi_s, sck_prev_q, cs_prev_q;
    assign cs_act = s_q[2];
    assign sck_s  = s_q[1];
    assign mosi_s = s_q[0];
    logic rise, fall, frame_end, frame_start;
    assign rise        = cs_act && sck_s && !sck_prev_q;
    assign fall        = cs_act && !sck_s && sck_prev_q;
    assign frame_end   = cs_prev_q && !cs_act;
    assign frame_start = cs_act && !cs_prev_q;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b0;
        end else if (ce_in) begin
            sck_prev_q <= sck_s;
            cs_prev_q  <= cs_act;
        end
    end
    // bit count saturates so long frames stay detectable
    logic [4:0] cnt_q;
    logic       over_q;
    sfsi_frame_t rx_q, tx_q, resp_q;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_q  <= 5'h00;
            over_q <= 1'b0;
            rx_q   <= FRAME_RESET;
        end else if (ce_in) begin
            if (frame_start) begin
                cnt_q  <= 5'h00;
                over_q <= 1'b0;
            end else if (rise) begin
                rx_q <= {rx_q[14:0], mosi_s};
                if (cnt_q == FRAME_BITS_C) over_q <= 1'b1;
                else cnt_q <= cnt_q + 5'h01;
            end
        end
    end
    logic [4:0] rx_addr;
    logic [7:0] rx_data;
    logic       len_ok, par_ok, good;
    assign rx_addr = rx_q[POS_ADDR_HI:POS_ADDR_LO];
    assign rx_data = rx_q[POS_DATA_HI:POS_DATA_LO];
    assign len_ok  = (cnt_q == FRAME_BITS_C) && !over_q;
    assign par_ok  = (rx_q[POS_PAR] == sfsi_odd_par(rx_q[15:1]));
    assign good    = len_ok && par_ok;
    // register bank; commit only on a clean frame end
    logic [7:0] regs_q [32];
    logic lock_q, outdis_q, swrst_q, err_q;
    logic wr_ok;
    assign wr_ok = frame_end && good && rx_addr != ADDR_RO_BANK;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < 32; i++) regs_q[i] <= REG_RESET;
            lock_q   <= 1'b0;
            outdis_q <= 1'b1;
            swrst_q  <= 1'b0;
        end else if (ce_in) begin
            swrst_q <= 1'b0;
            if (wr_ok) begin
                if (rx_addr == ADDR_LOCK_CMD) begin
                    lock_q  <= rx_data[LOCK_BIT];
                    swrst_q <= rx_data[SWRST_BIT];
                    if (rx_data[SWRST_BIT]) begin
                        for (int i = 0; i < 32; i++) regs_q[i] <= REG_RESET;
                        lock_q   <= 1'b0;
                        outdis_q <= 1'b1;
                    end
                end else if (rx_addr == ADDR_STAGE_CMD) begin
                    if (rx_data[STOP_BIT]) outdis_q <= 1'b1;
                    else if (rx_data[START_BIT]) outdis_q <= 1'b0;
                end else if (!lock_q) begin
                    regs_q[rx_addr] <= rx_data;
                end
            end
        end
    end
    // error flag reports on the previous frame only
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) err_q <= 1'b0;
        else if (ce_in && frame_end) err_q <= !good;
    end
    // answer built at frame end, loaded at next frame start
    logic [7:0]  ans_data;
    logic [4:0]  ans_addr;
    logic        ans_rw;
    always_comb begin
        ans_addr = rx_addr;
        ans_rw   = 1'b0;
        ans_data = 8'h00;
        if (rx_addr == ADDR_RO_BANK) begin
            ans_rw   = 1'b1;
            ans_addr = rx_data[4:0];
            ans_data = ro_data_in[rx_data[4:0]];
        end else if (rx_addr == ADDR_LOCK_CMD) begin
            // status after this write takes effect, soft reset unlocks
            ans_data[LOCK_BIT] = !rx_data[SWRST_BIT] && rx_data[LOCK_BIT];
        end else if (rx_addr == ADDR_STAGE_CMD) begin
            if (rx_data[STOP_BIT]) ans_data[OUTDIS_BIT] = 1'b1;
            else if (rx_data[START_BIT]) ans_data[OUTDIS_BIT] = 1'b0;
            else ans_data[OUTDIS_BIT] = outdis_q;
        end
    end
    logic ans_pend_q;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            resp_q     <= FRAME_RESET;
            ans_pend_q <= 1'b0;
        end else if (ce_in && frame_end) begin
            ans_pend_q <= good;
            if (good) resp_q[14:1] <= {ans_addr, ans_rw, ans_data};
            else resp_q[14:1] <= 14'h0000;
        end
    end
    logic [14:0] body;
    assign body = {err_q, resp_q[14:1]};
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) tx_q <= FRAME_RESET;
        else if (ce_in) begin
            if (frame_start) tx_q <= {body, sfsi_odd_par(body)};
            else if (fall) tx_q <= {tx_q[14:0], 1'b0};
        end
    end
    assign link.miso    = tx_q[POS_ERR];
    assign link.miso_oe = cs_act;
    always_comb for (int i = 0; i < 32; i++) wr_regs_out[i] = regs_q[i];
    assign lock_out      = lock_q;
    assign out_dis_out   = outdis_q;
    assign sw_reset_out  = swrst_q;
    assign frame_err_out = err_q;
    logic unused_pend;
    assign unused_pend = ans_pend_q;
endmodule : sfsi_device

/* File: sfsi_master.sv */
// master end: software port, frame engine and interrupt
`timescale 1ns/1ps
module sfsi_master
    import sfsi_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic        ce_in,
    sfsi_link_if.master      link,
    input  wire logic [7:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [15:0]      rdata_out,
    output logic             irq_out
);
    logic miso_s;
    sfsi_sync #(.W(1)) u_sync (
        .clk_sys_in (clk_sys_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .d_in       (link.miso),
        .rst_val_in (1'b0),
        .q_out      (miso_s)
    );
    sfsi_mst_state_t st_q;
    sfsi_frame_t tx_q, rx_q, txreg_q;
    logic [2:0] div_q;
    logic [4:0] bit_q;
    logic       sck_q, go, busy;
    logic [1:0] sts_q, mask_q;
    logic       ev_done, ev_perr;
    assign go   = wr_in && addr_in == REG_CTRL && wdata_in[0];
    assign busy = st_q != SFSI_IDLE;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) txreg_q <= FRAME_RESET;
        else if (ce_in && wr_in && addr_in == REG_TX && !busy)
            txreg_q <= {wdata_in[15:1], sfsi_odd_par(wdata_in[15:1])};
    end
    logic tick;
    assign tick = div_q == SCK_HALF_M1;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q  <= SFSI_IDLE;
            div_q <= 3'h0;
            bit_q <= 5'h00;
            sck_q <= 1'b0;
            tx_q  <= FRAME_RESET;
            rx_q  <= FRAME_RESET;
        end else if (ce_in) begin
            div_q <= (busy && !tick) ? div_q + 3'h1 : 3'h0;
            unique case (st_q)
                SFSI_IDLE: if (go) begin
                    tx_q  <= txreg_q;
                    bit_q <= 5'h00;
                    st_q  <= SFSI_LEAD;
                end
                SFSI_LEAD: if (tick) st_q <= SFSI_XFER;
                SFSI_XFER: if (tick) begin
                    if (!sck_q) begin
                        sck_q <= 1'b1;
                        rx_q  <= {rx_q[14:0], miso_s};
                    end else begin
                        sck_q <= 1'b0;
                        tx_q  <= {tx_q[14:0], 1'b0};
                        bit_q <= bit_q + 5'h01;
                        if (bit_q == FRAME_BITS_M1) st_q <= SFSI_LAG;
                    end
                end
                SFSI_LAG: if (tick) st_q <= SFSI_IDLE;
            endcase
        end
    end
    assign ev_done = ce_in && st_q == SFSI_LAG && tick;
    assign ev_perr = ev_done && rx_q[POS_PAR] != sfsi_odd_par(rx_q[15:1]);
    // sticky status: an event beats a clearing read
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sts_q  <= 2'h0;
            mask_q <= 2'h0;
        end else if (ce_in) begin
            if (wr_in && addr_in == REG_MASK) mask_q <= wdata_in[1:0];
            sts_q <= ((rd_in && addr_in == REG_STATUS) ? 2'h0 : sts_q)
                   | {ev_perr, ev_done};
        end
    end
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) rdata_out <= FRAME_RESET;
        else if (ce_in) begin
            rdata_out <= FRAME_RESET;
            if (rd_in) begin
                unique case (addr_in)
                    REG_STATUS: rdata_out <= {14'h0000, sts_q};
                    REG_MASK:   rdata_out <= {14'h0000, mask_q};
                    REG_TX:     rdata_out <= txreg_q;
                    REG_RX:     rdata_out <= rx_q;
                    REG_CTRL:   rdata_out <= {15'h0000, busy};
                    default:    rdata_out <= FRAME_RESET;
                endcase
            end
        end
    end
    assign irq_out   = |(sts_q & mask_q);
    assign link.cs_n = !busy;
    assign link.sck  = sck_q;
    assign link.mosi = tx_q[POS_ERR];
    logic unused_oe;
    assign unused_oe = link.miso_oe;
endmodule : sfsi_master

/* File: sfsi_sva.sv */
// checker of the serial link between master and device
`timescale 1ns/1ps
module sfsi_sva
    import sfsi_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic        sck_q;
    logic        cs_q;
    logic        seen_q;
    logic [4:0]  bits_q;
    logic [15:0] req_q;
    logic [15:0] ans_q;
    logic [15:0] prev_q;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    // sck is made in this clock domain, so a one-cycle look back finds its edges
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sck_q <= 1'b0;
            cs_q <= 1'b1;
            seen_q <= 1'b0;
            bits_q <= 5'h00;
            req_q <= 16'h0000;
            ans_q <= 16'h0000;
            prev_q <= 16'h0000;
        end else begin
            sck_q <= sck;
            cs_q <= cs_n;
            if (cs_q && !cs_n) begin
                bits_q <= 5'h00;
            end else if (!cs_n && sck && !sck_q) begin
                bits_q <= bits_q + 5'h01;
                req_q <= {req_q[14:0], mosi};
                ans_q <= {ans_q[14:0], miso};
            end
            if (cs_n && !cs_q) begin
                prev_q <= req_q;
                seen_q <= 1'b1;
            end
        end
    end
    idle_off_a: assert property (cs_n [*4] |-> !miso_oe) else $error("output driven while idle");
    sel_drive_a: assert property ($fell(cs_n) |-> ##[1:4] miso_oe)
        else $error("output not driven in frame");
    idle_sck_a: assert property (cs_n |-> !sck) else $error("clock moves while idle");
    lead_low_a: assert property ($fell(cs_n) |-> !sck [*4]) else $error("lead time short");
    mosi_hold_a: assert property (!cs_n && sck && $past(sck) |-> $stable(mosi))
        else $error("input bit moved while clock high");
    miso_hold_a: assert property (!cs_n && sck && $past(sck) |-> $stable(miso))
        else $error("output bit moved while clock high");
    bit_count_a: assert property ($rose(cs_n) |-> bits_q == FRAME_BITS_C)
        else $error("frame length wrong");
    req_par_a: assert property ($rose(cs_n) |-> ^req_q) else $error("request parity even");
    ans_par_a: assert property ($rose(cs_n) && seen_q |-> ^ans_q)
        else $error("answer parity even");
    ans_err_a: assert property ($rose(cs_n) && seen_q |-> !ans_q[POS_ERR])
        else $error("error flag after good frame");
    echo_addr_a: assert property ($rose(cs_n) && seen_q && prev_q[14:10] != ADDR_RO_BANK
        |-> ans_q[14:10] == prev_q[14:10] && !ans_q[POS_RW]) else $error("address echo wrong");
    bank_flag_a: assert property ($rose(cs_n) && seen_q && prev_q[14:10] == ADDR_RO_BANK
        |-> ans_q[POS_RW] && ans_q[14:10] == prev_q[5:1]) else $error("bank answer wrong");
    cover property ($rose(cs_n) && seen_q);
    cover property ($rose(cs_n) && prev_q[14:10] == ADDR_RO_BANK);
    cover property ($rose(miso_oe));
endmodule : sfsi_sva

/* File: spi_frame_slave_interface_bench.sv */
// bench: master and device joined over the link, plus a rule-breaking driver
`timescale 1ns/1ps
module spi_frame_slave_interface_bench;
    import sfsi_pkg::*;
    logic        clk_sys_in = 1'b0;
    logic        resetn_in  = 1'b0;
    logic [7:0]  addr_in    = 8'h00;
    logic [15:0] wdata_in   = 16'h0000;
    logic        wr_in      = 1'b0;
    logic        rd_in      = 1'b0;
    logic [15:0] rdata_out;
    logic        irq_out;
    logic        lock_out;
    logic        out_dis_out;
    logic [7:0]  ro [32];
    logic [7:0]  regs [32];
    logic [7:0]  regs2 [32];
    int          errors     = 0;
    int          cmp_count  = 0;
    logic [4:0]  t_a [9]    = '{5'h03, 5'h10, 5'h0C, 5'h03, 5'h0C, 5'h0D, 5'h0D, 5'h10, 5'h10};
    logic [7:0]  t_d [9]    = '{8'h5A, 8'h05, 8'h02, 8'h77, 8'h00, 8'h04, 8'h08, 8'h00, 8'h01};
    logic [7:0]  t_e [9]    = '{8'h00, 8'h85, 8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'h80, 8'h81};
    logic [8:0]  lock_v     = 9'h00C;
    logic [8:0]  dis_v      = 9'h1DF;
    logic [15:0] ans;
    logic [15:0] st;
    sfsi_link_if link ();
    sfsi_link_if l2 ();
    always #12.5 clk_sys_in = ~clk_sys_in;
    sfsi_master sfsi_master_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(1'b1),
        .link(link), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .irq_out(irq_out));
    sfsi_device sfsi_device_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(1'b1),
        .link(link), .ro_data_in(ro), .wr_regs_out(regs), .lock_out(lock_out),
        .out_dis_out(out_dis_out), .sw_reset_out(), .frame_err_out());
    sfsi_device sfsi_device_inst_b (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(1'b1),
        .link(l2), .ro_data_in(ro), .wr_regs_out(regs2), .lock_out(), .out_dis_out(),
        .sw_reset_out(), .frame_err_out());
    sfsi_sva sfsi_sva_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cs_n(link.cs_n),
        .sck(link.sck), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));
    function automatic logic [15:0] mk(input logic e, input logic [4:0] a, input logic w,
                                       input logic [7:0] d);
        return {e, a, w, d, ~^{e, a, w, d}};
    endfunction : mk
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask : rd
    task automatic xfer(input logic [4:0] a, input logic [7:0] d, output logic [15:0] r);
        int n;
        logic [15:0] b;
        wr(REG_TX, mk(1'b0, a, 1'b0, d));
        wr(REG_CTRL, 16'h0001);
        n = 0;
        do begin
            rd(REG_CTRL, b);
            n++;
        end while (b[0] !== 1'b0 && n < 500);
        if (n >= 500) begin
            chk(16'h0001, 16'h0000);
            close_out();
        end
        rd(REG_RX, r);
    endtask : xfer
    // stands in for a master that may send the wrong number of clocks
    task automatic bang(input int n, input logic [15:0] f, output logic [15:0] r);
        r = 16'h0000;
        @(posedge clk_sys_in);
        l2.cs_n <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        for (int i = 0; i < n; i++) begin
            l2.mosi <= (i < 16) ? f[15 - i] : 1'b0;
            repeat (4) @(posedge clk_sys_in);
            l2.sck <= 1'b1;
            if (i < 16) r = {r[14:0], l2.miso};
            repeat (4) @(posedge clk_sys_in);
            l2.sck <= 1'b0;
        end
        repeat (4) @(posedge clk_sys_in);
        l2.cs_n <= 1'b1;
        l2.mosi <= ~f[0];
        repeat (64) @(posedge clk_sys_in);
    endtask : bang
    initial begin
        repeat (50000) @(posedge clk_sys_in);
        chk(16'h0001, 16'h0000);
        close_out();
    end
    initial begin
        int i;
        logic bank;
        logic [4:0] ea;
        for (i = 0; i < 32; i++) ro[i] = {3'h4, i[4:0]};
        l2.cs_n = 1'b1;
        l2.sck = 1'b0;
        l2.mosi = 1'b0;
        repeat (12) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        rd(8'h20, st);
        chk(st, 16'h0000);
        wr(REG_MASK, 16'h0001);
        for (i = 0; i < 9; i++) begin
            if (i == 8) wr(REG_MASK, 16'h0000);
            xfer(t_a[i], t_d[i], ans);
            if (i > 0) begin
                bank = (t_a[i-1] == ADDR_RO_BANK);
                ea = bank ? t_d[i-1][4:0] : t_a[i-1];
                chk(ans, mk(1'b0, ea, bank, t_e[i-1]));
            end
            chk({15'h0, irq_out}, {15'h0, i != 8});
            rd(REG_STATUS, st);
            chk(i == 0 ? st & 16'h0001 : st, 16'h0001);
            chk({15'h0, irq_out}, 16'h0000);
            chk({14'h0, lock_out, out_dis_out}, {14'h0, lock_v[i], dis_v[i]});
            chk({8'h00, regs[3]}, 16'h005A);
            $display("frame test %0d done", i);
        end
        bang(15, mk(1'b0, 5'h03, 1'b0, 8'h33), ans);
        chk({8'h00, regs2[3]}, 16'h0000);
        bang(16, mk(1'b0, 5'h01, 1'b0, 8'h00), ans);
        chk({7'h0, ans[15], ans[8:1]}, 16'h0100);
        bang(16, mk(1'b0, 5'h03, 1'b0, 8'h44) ^ 16'h0001, ans);
        chk({15'h0, ans[15]}, 16'h0000);
        chk({8'h00, regs2[3]}, 16'h0000);
        bang(17, mk(1'b0, 5'h03, 1'b0, 8'h55), ans);
        chk({15'h0, ans[15]}, 16'h0001);
        chk({8'h00, regs2[3]}, 16'h0000);
        bang(16, mk(1'b0, 5'h03, 1'b0, 8'h66), ans);
        chk({15'h0, ans[15]}, 16'h0001);
        chk({8'h00, regs2[3]}, 16'h0066);
        bang(16, mk(1'b0, 5'h01, 1'b0, 8'h00), ans);
        chk(ans, mk(1'b0, 5'h03, 1'b0, 8'h00));
        $display("faulty frame test done");
        close_out();
    end
endmodule : spi_frame_slave_interface_bench
